// ---- core/pdt_params.svh ----
// Constants of the prescaled down timer: offsets, fields, reset values, dividers.
// Assumes inclusion by bare name from design and bench files.
`ifndef PDT_PARAMS_SVH
`define PDT_PARAMS_SVH
`define PDT_ADDR_STATUS_CONTROL 8'h09
`define PDT_ADDR_PRESCALER 8'hFD
`define PDT_ADDR_COUNT 8'hFE
`define PDT_BIT_TIMEOUT 7
`define PDT_BIT_DIRECTION 5
`define PDT_BIT_PIN_VALUE 4
`define PDT_BIT_RUN 3
`define PDT_SEL_LSB 0
`define PDT_SEL_MSB 2
`define PDT_RESET_COUNT 8'hFF
`define PDT_RESET_PRESCALER 7'h7F
`define PDT_RESET_STATUS 8'h00
`define PDT_CONTROL_MASK 8'h3F
`define PDT_PHASE_DIV 4
`define PDT_BYTE_DIV 12
`endif

// ---- core/pdt_pkg.sv ----
// Types of the prescaled down timer.
// Assumes pdt_params.svh supplies the numeric constants.
package pdt_pkg;
	typedef logic [7:0] pdt_byte_type;
	typedef logic [6:0] pdt_prescale_type;
	typedef logic [2:0] pdt_select_type;
endpackage

// ---- core/pdt_timer.sv ----
// Prescaled down timer: 8-bit count, 7-bit prescaler, status/control register.
// Assumes a one-cycle register access port from the CPU on the same clock;
// i_clock stands for the oscillator; the timer pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_params.svh"
module pdt_timer (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic [7:0] i_address,
	input wire logic i_write,
	input wire logic i_read,
	input wire logic [7:0] i_write_data,
	output logic [7:0] o_read_data,
	input wire logic i_timer_pin,
	output logic o_timer_pin,
	output logic o_timer_pin_oe,
	output logic o_timeout_flag
);
	pdt_pkg::pdt_byte_type timer_count, next_timer_count;
	pdt_pkg::pdt_prescale_type prescaler, next_prescaler;
	pdt_pkg::pdt_byte_type control, next_control;
	logic timeout_flag, next_timeout_flag;
	logic out_latch, next_out_latch;
	logic [1:0] phase_div, next_phase_div;
	logic [3:0] byte_div, next_byte_div;
	logic sync_pulse, next_sync_pulse;
	logic pin_meta, pin_sync, pin_prev;
	logic next_pin_meta, next_pin_sync, next_pin_prev;
	pdt_pkg::pdt_byte_type read_data, next_read_data;
	logic prescale_tick, count_tick, pin_edge, direction, run;
	logic wr_count, wr_prescaler, wr_status, rd_status;
	logic timeout_set, next_pin_oe;
	pdt_pkg::pdt_select_type select;

	// Tap of the down-counting prescaler at the selected power of two
	function automatic logic tap_fires(input pdt_pkg::pdt_prescale_type value,
		input pdt_pkg::pdt_select_type sel);
		pdt_pkg::pdt_prescale_type mask;
		mask = pdt_pkg::pdt_prescale_type'((8'h01 << sel) - 8'h01);
		tap_fires = ((value & mask) == 7'h00);
	endfunction

	// Pin synchroniser and edge detector
	always_comb begin
		next_pin_meta = i_timer_pin;
		next_pin_sync = pin_meta;
		next_pin_prev = pin_sync;
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_meta <= next_pin_meta;
			pin_sync <= next_pin_sync;
			pin_prev <= next_pin_prev;
		end
	end

	always_comb begin
		direction = control[`PDT_BIT_DIRECTION];
		run = control[`PDT_BIT_RUN];
		select = control[`PDT_SEL_MSB:`PDT_SEL_LSB];
		pin_edge = pin_sync & ~pin_prev;
		wr_count = i_write && (i_address == `PDT_ADDR_COUNT);
		wr_prescaler = i_write && (i_address == `PDT_ADDR_PRESCALER);
		wr_status = i_write && (i_address == `PDT_ADDR_STATUS_CONTROL);
		rd_status = i_read && (i_address == `PDT_ADDR_STATUS_CONTROL);
		// Clock source select, one enable per prescaler clock
		prescale_tick = run && (direction ? sync_pulse : pin_edge);
		count_tick = prescale_tick && tap_fires(prescaler, select);
		// A write to either counter suppresses the timeout of that cycle
		timeout_set = count_tick && (timer_count == 8'h01) && !wr_count && !wr_prescaler;
	end

	// Byte-cycle sync: oscillator / 4 then / 12
	always_comb begin
		next_phase_div = phase_div + 2'h1;
		next_byte_div = byte_div;
		next_sync_pulse = 1'b0;
		if (phase_div == 2'(`PDT_PHASE_DIV - 1)) begin
			if (byte_div == 4'(`PDT_BYTE_DIV - 1)) begin
				next_byte_div = 4'h0;
				next_sync_pulse = 1'b1;
			end else begin
				next_byte_div = byte_div + 4'h1;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			phase_div <= 2'h0;
			byte_div <= 4'h0;
			sync_pulse <= 1'b0;
		end else begin
			phase_div <= next_phase_div;
			byte_div <= next_byte_div;
			sync_pulse <= next_sync_pulse;
		end
	end

	// Prescaler and count; a write lands last so it beats a decrement
	always_comb begin
		next_timer_count = timer_count;
		next_prescaler = prescaler;
		if (!run) begin
			next_prescaler = `PDT_RESET_PRESCALER;
		end else if (prescale_tick) begin
			next_prescaler = prescaler - 7'h01;
		end
		if (count_tick) begin
			next_timer_count = timer_count - 8'h01;
		end
		if (wr_prescaler) begin
			next_prescaler = i_write_data[6:0];
		end
		if (wr_count) begin
			next_timer_count = i_write_data;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			timer_count <= `PDT_RESET_COUNT;
			prescaler <= `PDT_RESET_PRESCALER;
		end else begin
			timer_count <= next_timer_count;
			prescaler <= next_prescaler;
		end
	end

	// Status, control, output latch and pin direction
	always_comb begin
		next_control = control;
		next_timeout_flag = timeout_flag;
		next_out_latch = out_latch;
		if (rd_status && timeout_flag) begin
			next_timeout_flag = 1'b0;
		end
		// Set sources come after the read clear, so a set wins
		if (timeout_set) begin
			next_timeout_flag = 1'b1;
		end
		if (wr_count && i_write_data == 8'h00) begin
			next_timeout_flag = 1'b1;
		end
		if (wr_status) begin
			next_control = i_write_data & `PDT_CONTROL_MASK;
			next_timeout_flag = 1'b1;
		end
		// The latch takes the control byte as it stands after a write
		if (next_control[`PDT_BIT_DIRECTION] && next_timeout_flag && !timeout_flag) begin
			next_out_latch = next_control[`PDT_BIT_PIN_VALUE];
		end
		next_pin_oe = next_control[`PDT_BIT_DIRECTION];
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			control <= `PDT_RESET_STATUS;
			timeout_flag <= 1'b0;
			out_latch <= 1'b1;
			o_timer_pin_oe <= 1'b0;
		end else begin
			control <= next_control;
			timeout_flag <= next_timeout_flag;
			out_latch <= next_out_latch;
			o_timer_pin_oe <= next_pin_oe;
		end
	end

	// Read data of the three locations, zero elsewhere
	always_comb begin
		next_read_data = 8'h00;
		if (i_read) begin
			unique case (i_address)
				`PDT_ADDR_COUNT: next_read_data = timer_count;
				`PDT_ADDR_PRESCALER: next_read_data = {1'b0, prescaler};
				`PDT_ADDR_STATUS_CONTROL: next_read_data = {timeout_flag, control[6:0]};
				default: next_read_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			read_data <= 8'h00;
		end else begin
			read_data <= next_read_data;
		end
	end

	assign o_timer_pin = out_latch;
	assign o_timeout_flag = timeout_flag;
	assign o_read_data = read_data;
endmodule // pdt_timer
`default_nettype wire

// ---- test/pdt_checker.sv ----
// Port checks of the prescaled down timer.
// Assumes binding into pdt_timer.
`timescale 1ns/1ps
`default_nettype none
module pdt_checker (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic [7:0] i_address,
	input wire logic i_write,
	input wire logic i_read,
	input wire logic [7:0] i_write_data,
	input wire logic [7:0] o_read_data,
	input wire logic o_timer_pin,
	input wire logic o_timer_pin_oe,
	input wire logic o_timeout_flag
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	sequence s_wr(a);
		i_write && i_address == a;
	endsequence
	sequence s_rd(a);
		i_read && i_address == a;
	endsequence
	AST_OE: assert property (s_wr(8'h09) |=> o_timer_pin_oe == $past(i_write_data[5]))
		else $error("pin direction wrong");
	AST_FLAG_WR: assert property (s_wr(8'h09) && !i_read |=> o_timeout_flag)
		else $error("status write left flag low");
	AST_ZERO_WR: assert property (s_wr(8'hFE) && i_write_data == 8'h00 |=> o_timeout_flag)
		else $error("zero count write left flag low");
	AST_RD_CLEAR: assert property (s_rd(8'h09) && o_timeout_flag && !i_write |=> o_read_data[7] && !o_timeout_flag)
		else $error("flag read not cleared");
	AST_FLAG_FALL: assert property ($fell(o_timeout_flag) |-> $past(i_read) && $past(i_address) == 8'h09)
		else $error("flag fell without status read");
	AST_LATCH: assert property ($changed(o_timer_pin) |-> $rose(o_timeout_flag) && o_timer_pin_oe)
		else $error("output latch moved without timeout");
	AST_UNMAP: assert property (i_read && !(i_address inside {8'h09, 8'hFD, 8'hFE}) |=> o_read_data == 8'h00)
		else $error("unmapped read not zero");
	AST_IDLE: assert property (!i_read |=> o_read_data == 8'h00)
		else $error("read data without read");
endmodule // pdt_checker
bind pdt_timer pdt_checker pdt_checker_i (.i_clock, .i_reset_n, .i_address, .i_write, .i_read,
	.i_write_data, .o_read_data, .o_timer_pin, .o_timer_pin_oe, .o_timeout_flag);
`default_nettype wire

// ---- test/pdt_pin_model.sv ----
// Clock source or load on the timer pin.
// Assumes the pin is shared with the timer's output driver.
`timescale 1ns/1ps
`default_nettype none
module pdt_pin_model #(parameter int HALF = 30) (
	input wire logic i_clock,
	input wire logic i_run,
	input wire logic i_oe,
	input wire logic i_drive,
	output logic o_pin
);
	int n = 0;
	logic src = 1'h0;
	always @(posedge i_clock) begin
		n <= (n == HALF - 1) ? 0 : n + 1;
		if (i_run && n == HALF - 1) src <= ~src;
	end
	assign o_pin = i_oe ? i_drive : src;
endmodule // pdt_pin_model
`default_nettype wire

// ---- test/testbench.sv ----
// Register-level tests of the prescaled down timer.
// Assumes a 40 MHz clock and a pin clock model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clock = 1'h0, i_reset_n = 1'h0, i_write = 1'h0, i_read = 1'h0, ext = 1'h0;
	logic [7:0] i_address = 8'h00, i_write_data = 8'h00, o_read_data;
	logic o_timer_pin, o_timer_pin_oe, o_timeout_flag;
	wire i_timer_pin;
	int errors = 0, n_checks = 0;
	always #12.5 i_clock = ~i_clock;
	pdt_timer pdt_timer_i (.i_clock, .i_reset_n, .i_address, .i_write, .i_read, .i_write_data,
		.o_read_data, .i_timer_pin, .o_timer_pin, .o_timer_pin_oe, .o_timeout_flag);
	pdt_pin_model pdt_pin_model_i (.i_clock, .i_run(ext), .i_oe(o_timer_pin_oe),
		.i_drive(o_timer_pin), .o_pin(i_timer_pin));
	task automatic close_out;
		if (errors == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(posedge i_clock);
		#1 {i_write, i_read, i_address, i_write_data} = {w, !w, a, d};
		@(posedge i_clock);
		#1 {i_write, i_read} = 2'h0;
	endtask
	task automatic rdc(input logic [7:0] a, e);
		acc(1'h0, a, 8'h00);
		chk(o_read_data, e);
	endtask
	task automatic tm(input logic [7:0] c, input int p);
		int n = 0;
		acc(1'h1, 8'hFE, 8'hFF);
		acc(1'h1, 8'h09, c);
		acc(1'h0, 8'h09, 8'h00);
		acc(1'h1, 8'hFE, 8'h02);
		while (o_timeout_flag !== 1'h1 && n < 13000) begin
			@(posedge i_clock);
			#1 n++;
		end
		chk(8'(n > p - 4 && n <= 2 * p + 4), 8'h01);
	endtask
	initial begin
		repeat (20) @(posedge i_clock);
		#1 i_reset_n = 1'h1;
		rdc(8'hFE, 8'hFF);
		rdc(8'hFD, 8'h7F);
		rdc(8'h09, 8'h00);
		chk({6'h00, o_timer_pin_oe, o_timer_pin}, 8'h01);
		rdc(8'h10, 8'h00);
		acc(1'h1, 8'h09, 8'h30);
		rdc(8'h09, 8'hB0);
		rdc(8'h09, 8'h30);
		acc(1'h1, 8'h09, 8'h20);
		chk({6'h00, o_timer_pin_oe, o_timer_pin}, 8'h02);
		rdc(8'h09, 8'hA0);
		acc(1'h1, 8'hFE, 8'h00);
		rdc(8'h09, 8'hA0);
		for (int s = 0; s < 8; s++) tm(8'h28 | 8'(s), 48 << s);
		ext = 1'h1;
		tm(8'h08, 60);
		acc(1'h1, 8'h09, 8'h00);
		acc(1'h1, 8'hFE, 8'h55);
		repeat (300) @(posedge i_clock);
		rdc(8'hFE, 8'h55);
		rdc(8'hFD, 8'h7F);
		close_out;
	end
	initial begin
		#1500000;
		errors++;
		close_out;
	end
endmodule // testbench
`default_nettype wire
